// *** pss_pkg.sv ***
// Package for the port-4 serial pin select block.
// Holds register indices, reset values, pad and mode codes
// and the pad drive bundle. Assumes a 32-bit APB master.
package pss_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [17:0] IDX_OUTPUT_DATA = 18'h0_f220;
  localparam logic [17:0] IDX_DIRECTION = 18'h0_f221;
  localparam logic [17:0] IDX_PAD_LOW = 18'h0_f222;
  localparam logic [17:0] IDX_PAD_HIGH = 18'h0_f223;
  localparam logic [17:0] IDX_FUNC_LOW = 18'h0_f224;
  localparam logic [17:0] IDX_FUNC_HIGH = 18'h0_f225;
  localparam logic [17:0] IDX_PIN_LEVEL = 18'h0_f226;

  // Slots of the register array, counted from the data register
  localparam logic [2:0] SLOT_OUTPUT_DATA = 3'h0;
  localparam logic [2:0] SLOT_DIRECTION = 3'h1;
  localparam logic [2:0] SLOT_PAD_LOW = 3'h2;
  localparam logic [2:0] SLOT_PAD_HIGH = 3'h3;
  localparam logic [2:0] SLOT_FUNC_LOW = 3'h4;
  localparam logic [2:0] SLOT_FUNC_HIGH = 3'h5;
  localparam logic [2:0] SLOT_PIN_LEVEL = 3'h6;
  localparam int NUM_SLOTS = 7;

  // Reset values
  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PAD_LOW = 8'h00;
  localparam logic [7:0] RST_PAD_HIGH = 8'h00;
  localparam logic [7:0] RST_FUNC_LOW = 8'h00;
  localparam logic [7:0] RST_FUNC_HIGH = 8'h00;

  // Pin positions of the serial function
  localparam int BIT_SER_OUT = 6;
  localparam int BIT_SER_CLK = 5;
  localparam int BIT_SER_IN = 4;

  // Pad codes {high bit, low bit}
  localparam logic [1:0] PAD_HIZ = 2'h0;
  localparam logic [1:0] PAD_OPEN_LOW = 2'h1;
  localparam logic [1:0] PAD_OPEN_HIGH = 2'h2;
  localparam logic [1:0] PAD_CMOS = 2'h3;

  // Function code {high bit, low bit} that selects the serial port
  localparam logic [1:0] FUNC_SERIAL = 2'h2;

  // Drive bundle for the eight port pins
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } pss_pad_s;

endpackage : pss_pkg

// *** pss_pin_select.sv ***
// Port-4 pin multiplexer and pad control with serial function on 6..4.
// Assumes a 32-bit APB master on pclk and a serial engine on pclk;
// pad inputs are asynchronous and are synchronised here.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps

module pss_pin_select (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pads
  input wire logic [7:0] pin_in,
  output pss_pkg::pss_pad_s pad_drive,
  // Serial engine
  input wire logic serial_data_out,
  input wire logic serial_clock_line_out,
  output logic serial_data_in,
  output logic serial_clock_line_in,
  output logic serial_clock_slave,
  output logic serial_pins_selected
);

  logic [7:0] regs_q [pss_pkg::NUM_SLOTS-1];
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] level_q;
  logic [7:0] oe_n_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic slave_q;
  logic selected_q;

  logic [17:0] word_idx;
  logic [17:0] slot_wide;
  logic [2:0] slot;
  logic hit;
  logic setup;
  logic wr_access;
  logic [7:0] read_byte;
  logic [7:0] ser_sel;
  logic [7:0] drive_val;

  // Address decode: one aligned word per register
  assign word_idx = paddr[19:2];
  assign slot_wide = word_idx - pss_pkg::IDX_OUTPUT_DATA;
  assign slot = slot_wide[2:0];
  assign hit = (paddr[1:0] == 2'h0) &&
               (word_idx >= pss_pkg::IDX_OUTPUT_DATA) &&
               (word_idx <= pss_pkg::IDX_PIN_LEVEL);
  assign setup = psel && !penable;
  // Zero wait states: the answer is ready in the access phase
  assign pready = penable;
  assign wr_access = psel && penable && pwrite && hit;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    if (slot == pss_pkg::SLOT_PIN_LEVEL) begin
      read_byte = sync2_q;
    end else begin
      read_byte = regs_q[slot];
    end
  end

  // Writable registers; the pin level slot is read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_q[pss_pkg::SLOT_OUTPUT_DATA] <= pss_pkg::RST_OUTPUT_DATA;
      regs_q[pss_pkg::SLOT_DIRECTION] <= pss_pkg::RST_DIRECTION;
      regs_q[pss_pkg::SLOT_PAD_LOW] <= pss_pkg::RST_PAD_LOW;
      regs_q[pss_pkg::SLOT_PAD_HIGH] <= pss_pkg::RST_PAD_HIGH;
      regs_q[pss_pkg::SLOT_FUNC_LOW] <= pss_pkg::RST_FUNC_LOW;
      regs_q[pss_pkg::SLOT_FUNC_HIGH] <= pss_pkg::RST_FUNC_HIGH;
    end else if (wr_access && slot != pss_pkg::SLOT_PIN_LEVEL) begin
      regs_q[slot] <= pwdata[7:0];
    end
  end

  // Read data and error are taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= (hit && !pwrite) ? {24'h00_0000, read_byte}
                                   : 32'h0000_0000;
      pslverr_q <= !hit;
    end
  end

  // Two-flop synchroniser for the pad inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Serial inputs follow the pins whatever drives them, so a slave
  // clock is seen even while software is still setting direction.
  assign serial_data_in = sync2_q[pss_pkg::BIT_SER_IN];
  assign serial_clock_line_in = sync2_q[pss_pkg::BIT_SER_CLK];

  // Per-pin function select and drive value
  for (genvar i = 0; i < 8; i++) begin : g_pin
    if (i >= pss_pkg::BIT_SER_IN && i <= pss_pkg::BIT_SER_OUT) begin : g_ser
      // Same select code for master and slave
      assign ser_sel[i] = {regs_q[pss_pkg::SLOT_FUNC_HIGH][i],
                           regs_q[pss_pkg::SLOT_FUNC_LOW][i]}
                          == pss_pkg::FUNC_SERIAL;
    end else begin : g_plain
      assign ser_sel[i] = 1'b0;
    end

    always_comb begin
      if (!ser_sel[i]) begin
        drive_val[i] = regs_q[pss_pkg::SLOT_OUTPUT_DATA][i];
      end else if (i == pss_pkg::BIT_SER_OUT) begin
        drive_val[i] = serial_data_out;
      end else if (i == pss_pkg::BIT_SER_CLK) begin
        drive_val[i] = serial_clock_line_out;
      end else begin
        // Data-in pin has nothing to send; port data stays ignored
        drive_val[i] = 1'b0;
      end
    end

    // Pad stage registered so the pins never see decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        level_q[i] <= 1'b0;
        oe_n_q[i] <= 1'b1;
      end else if (regs_q[pss_pkg::SLOT_DIRECTION][i]) begin
        level_q[i] <= 1'b0;
        oe_n_q[i] <= 1'b1;
      end else begin
        unique case ({regs_q[pss_pkg::SLOT_PAD_HIGH][i],
                      regs_q[pss_pkg::SLOT_PAD_LOW][i]})
          pss_pkg::PAD_CMOS: begin
            level_q[i] <= drive_val[i];
            oe_n_q[i] <= 1'b0;
          end
          pss_pkg::PAD_OPEN_LOW: begin
            level_q[i] <= 1'b0;
            oe_n_q[i] <= drive_val[i];
          end
          pss_pkg::PAD_OPEN_HIGH: begin
            level_q[i] <= 1'b1;
            oe_n_q[i] <= !drive_val[i];
          end
          pss_pkg::PAD_HIZ: begin
            level_q[i] <= 1'b0;
            oe_n_q[i] <= 1'b1;
          end
        endcase
      end
    end
  end

  assign pad_drive.level = level_q;
  assign pad_drive.oe_n = oe_n_q;

  // Status to the serial engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_q <= 1'b0;
      selected_q <= 1'b0;
    end else begin
      slave_q <= ser_sel[pss_pkg::BIT_SER_CLK] &&
                 regs_q[pss_pkg::SLOT_DIRECTION][pss_pkg::BIT_SER_CLK];
      selected_q <= &ser_sel[pss_pkg::BIT_SER_OUT:pss_pkg::BIT_SER_IN];
    end
  end

  assign serial_clock_slave = slave_q;
  assign serial_pins_selected = selected_q;

  // Pad bits of input pins are left to software; no check is made.

  AST_SER_OUT_CMOS: assert property (
    @(posedge pclk) disable iff (!presetn)
    ser_sel[6] && !regs_q[1][6] && regs_q[3][6] && regs_q[2][6]
    |=> oe_n_q[6] == 1'b0 && level_q[6] == $past(serial_data_out))
    else $error("pin 6 does not carry serial data out");

  AST_MASTER_CLK: assert property (
    @(posedge pclk) disable iff (!presetn)
    ser_sel[5] && !regs_q[1][5] && regs_q[3][5] && regs_q[2][5]
    |=> !oe_n_q[5] && level_q[5] == $past(serial_clock_line_out)
        && !serial_clock_slave)
    else $error("pin 5 does not drive the serial clock");

  AST_MASTER_IN: assert property (
    @(posedge pclk) disable iff (!presetn)
    ser_sel[4] && regs_q[1][4] |=> oe_n_q[4])
    else $error("pin 4 driven while set as input");

  AST_SYNC_IN: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##2 serial_data_in == $past(pin_in[4], 2))
    else $error("serial data in is not the pin two cycles back");

  AST_SLAVE_ONLY_OUT: assert property (
    @(posedge pclk) disable iff (!presetn)
    ser_sel[6] && ser_sel[5] && regs_q[1][5] && regs_q[1][4]
    && !regs_q[1][6] && regs_q[3][6] && regs_q[2][6]
    |=> !oe_n_q[6] && oe_n_q[5] && oe_n_q[4])
    else $error("slave pads are not out, in, in");

  AST_SLAVE_CLK: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(ser_sel[5] && regs_q[1][5]) |-> ##1 serial_clock_slave
    ##1 serial_clock_line_in == $past(pin_in[5], 2))
    else $error("slave clock not taken from pin 5");

  AST_SAME_SELECT: assert property (
    @(posedge pclk) disable iff (!presetn)
    regs_q[5][6:4] == 3'h7 && regs_q[4][6:4] == 3'h0
    |=> serial_pins_selected)
    else $error("serial function not selected by its code");

  AST_DATA_IGNORED: assert property (
    @(posedge pclk) disable iff (!presetn)
    ser_sel[4] && !regs_q[1][4] && regs_q[3][4] && regs_q[2][4]
    |=> level_q[4] == 1'b0)
    else $error("port data reached the serial data-in pin");

  AST_PLAIN_BIT7: assert property (
    @(posedge pclk) disable iff (!presetn)
    !regs_q[1][7] && regs_q[3][7] && regs_q[2][7]
    |=> !oe_n_q[7] && level_q[7] == $past(regs_q[0][7]))
    else $error("bit 7 does not follow port data");

  AST_UNMAPPED: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !hit |=> pslverr && pready)
    else $error("unmapped access not answered with error");

  AST_WRITE_LANDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_access && slot == 3'h1 |=> regs_q[1] == $past(pwdata[7:0]))
    else $error("direction write did not land");

  // Reset, direction, status, clock sync and data fallback
  AST_RESET_STATE: assert property (
    @(posedge pclk)
    !presetn |=> oe_n_q == 8'hff && level_q == 8'h00 && !pslverr_q
                 && !slave_q && !selected_q && prdata_q == 32'h0000_0000)
    else $error("pads or status not at reset value");

  AST_DIR_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (oe_n_q & $past(regs_q[1])) == $past(regs_q[1])
             && (level_q & $past(regs_q[1])) == 8'h00)
    else $error("pad driven although its direction is input");

  AST_SLAVE_IN_PADS: assert property (
    @(posedge pclk) disable iff (!presetn)
    ser_sel[5] && ser_sel[4] && regs_q[1][5] && regs_q[1][4]
    |=> serial_clock_slave && oe_n_q[5] && oe_n_q[4])
    else $error("slave clock and data pins not taken as inputs");

  AST_SYNC_CLK: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##2 serial_clock_line_in == $past(pin_in[5], 2))
    else $error("serial clock in is not the pin two cycles back");

  AST_SER_SELECT: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_pins_selected |-> $past(&ser_sel[6:4]))
    else $error("serial pins flagged without their select code");

  AST_SELECT_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(regs_q[5][6] && !regs_q[4][6]) |=> !serial_pins_selected)
    else $error("serial pins flagged under another function code");

  AST_FALLBACK_DATA: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ser_sel[6] && !regs_q[1][6] && regs_q[3][6] && regs_q[2][6]
    |=> !oe_n_q[6] && level_q[6] == $past(regs_q[0][6]))
    else $error("pin 6 does not follow port data off the serial code");

  // Plain bits under each pad code
  AST_PLAIN_BIT3: assert property (
    @(posedge pclk) disable iff (!presetn)
    !regs_q[1][3] && regs_q[3][3] && regs_q[2][3]
    |=> !oe_n_q[3] && level_q[3] == $past(regs_q[0][3]))
    else $error("bit 3 does not follow port data");

  AST_OPEN_LOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    !regs_q[1][3] && !regs_q[3][3] && regs_q[2][3]
    |=> !level_q[3] && oe_n_q[3] == $past(regs_q[0][3]))
    else $error("open-drain low pad does not follow port data");

  AST_OPEN_HIGH: assert property (
    @(posedge pclk) disable iff (!presetn)
    !regs_q[1][7] && regs_q[3][7] && !regs_q[2][7]
    |=> level_q[7] && oe_n_q[7] == !$past(regs_q[0][7]))
    else $error("open-drain high pad does not follow port data");

  AST_PAD_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    !regs_q[1][0] && !regs_q[3][0] && !regs_q[2][0]
    |=> oe_n_q[0] && !level_q[0])
    else $error("pad driven although its pad code is off");

  // Bus answers
  AST_UNMAPPED_DATA: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !hit |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  AST_PIN_LEVEL_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && hit && !pwrite && slot == 3'h6
    |=> prdata == {24'h00_0000, $past(sync2_q)})
    else $error("pin level read is not the synchronised pins");

  AST_DATA_LANDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_access && slot == 3'h0 |=> regs_q[0] == $past(pwdata[7:0]))
    else $error("output data write did not land");

endmodule : pss_pin_select

// *** pss_far_side.sv ***
// Far side model: serial engine and outside circuit on the port pads.
// Assumes pclk and presetn are shared with the pin select block.
`timescale 1ns/10ps
module pss_far_side (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pads
  input wire pss_pkg::pss_pad_s pad_drive,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in,
  // Engine
  output logic serial_data_out,
  output logic serial_clock_line_out
);
  logic [2:0] cnt_q;
  // A driven pad wins, else the circuit that software set pads for
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pad_drive.oe_n[i] ? ext_level[i] : pad_drive.level[i];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Clock moves every cycle, data slower, so a swap of the two shows
  assign serial_clock_line_out = cnt_q[0];
  assign serial_data_out = cnt_q[2];
endmodule : pss_far_side

// *** testbench.sv ***
// Self-checking bench for the port-4 serial pin select block.
// Assumes APB with zero wait states and the far side model.
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pin_in, ext_level;
  logic sdo, sclk, sdi, scli, sslave, ssel, e5, e6;
  logic [7:0] rst_val [6];
  pss_pkg::pss_pad_s pad_drive;
  int errors, checked;

  pss_pin_select pss_pin_select_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pad_drive(pad_drive), .serial_data_out(sdo),
    .serial_clock_line_out(sclk), .serial_data_in(sdi),
    .serial_clock_line_in(scli), .serial_clock_slave(sslave),
    .serial_pins_selected(ssel));
  pss_far_side pss_far_side_inst (.pclk(pclk), .presetn(presetn),
    .pad_drive(pad_drive), .ext_level(ext_level), .pin_in(pin_in),
    .serial_data_out(sdo), .serial_clock_line_out(sclk));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // One APB transfer, held until pready is seen, then an idle cycle
  task automatic apb(input logic w, input logic [17:0] idx,
                     input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [17:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
    chk("write error", 32'h0000_0000, {31'h0000_0000, err});
  endtask : wr

  task automatic rdchk(input logic [17:0] idx, input logic [7:0] v);
    apb(1'b0, idx, 8'h00);
    chk("read data", {24'h00_0000, v}, rd);
  endtask : rdchk

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask : settle

  // Pins 6 and 5 must follow the engine one edge late
  task automatic track();
    e6 = sdo;
    e5 = sclk;
    repeat (8) begin
      @(posedge pclk);
      chk("pin6 level", {31'h0000_0000, e6}, {31'h0000_0000, pad_drive.level[6]});
      chk("pin5 level", {31'h0000_0000, e5}, {31'h0000_0000, pad_drive.level[5]});
      e6 = sdo;
      e5 = sclk;
    end
  endtask : track

  task automatic test_done();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #20000;
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h0_0000;
    pwdata = 32'h0000_0000;
    ext_level = 8'h00;
    rst_val = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset oe_n", 32'h0000_00ff, {24'h00_0000, pad_drive.oe_n});
    for (int i = 0; i < 6; i++) begin
      rdchk(pss_pkg::IDX_OUTPUT_DATA + 18'(i), rst_val[i]);
    end
    apb(1'b0, 18'h0_f227, 8'h00);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped data", 32'h0000_0000, rd);
    for (int i = 0; i < 6; i++) begin
      wr(pss_pkg::IDX_OUTPUT_DATA + 18'(i), 8'h3c ^ 8'(i));
      rdchk(pss_pkg::IDX_OUTPUT_DATA + 18'(i), 8'h3c ^ 8'(i));
    end
    // Plain port use of every pin, looped back through the pin level
    wr(pss_pkg::IDX_FUNC_HIGH, 8'h00);
    wr(pss_pkg::IDX_FUNC_LOW, 8'h00);
    wr(pss_pkg::IDX_PAD_HIGH, 8'hff);
    wr(pss_pkg::IDX_PAD_LOW, 8'hff);
    wr(pss_pkg::IDX_DIRECTION, 8'h00);
    wr(pss_pkg::IDX_OUTPUT_DATA, 8'ha5);
    settle();
    chk("port level", 32'h0000_00a5, {24'h00_0000, pad_drive.level});
    chk("port oe_n", 32'h0000_0000, {24'h00_0000, pad_drive.oe_n});
    rdchk(pss_pkg::IDX_PIN_LEVEL, 8'ha5);
    // Open-drain high, CMOS, open-drain low and off, two bits each
    wr(pss_pkg::IDX_PAD_HIGH, 8'hf0);
    wr(pss_pkg::IDX_PAD_LOW, 8'h3c);
    settle();
    chk("code level", 32'h0000_00e0, {24'h00_0000, pad_drive.level});
    chk("code oe_n", 32'h0000_0047, {24'h00_0000, pad_drive.oe_n});
    // Master: pin 4 input with its pad off
    wr(pss_pkg::IDX_PAD_HIGH, 8'hef);
    wr(pss_pkg::IDX_PAD_LOW, 8'hef);
    wr(pss_pkg::IDX_DIRECTION, 8'h10);
    wr(pss_pkg::IDX_FUNC_HIGH, 8'h70);
    ext_level <= 8'h10;
    settle();
    chk("master oe_n", 32'h0000_0010, {24'h00_0000, pad_drive.oe_n});
    chk("master select", 32'h0000_0001, {31'h0000_0000, ssel});
    chk("master data in", 32'h0000_0001, {31'h0000_0000, sdi});
    chk("other bits", 32'h0000_0085, {24'h00_0000, pad_drive.level & 8'h8f});
    track();
    wr(pss_pkg::IDX_OUTPUT_DATA, 8'hd5);
    ext_level <= 8'h00;
    settle();
    track();
    chk("master data in low", 32'h0000_0000, {31'h0000_0000, sdi});
    // Slave: of the serial pins only pin 6 driven, clock and data from outside
    wr(pss_pkg::IDX_DIRECTION, 8'h30);
    ext_level <= 8'h20;
    settle();
    chk("slave oe_n", 32'h0000_0030, {24'h00_0000, pad_drive.oe_n});
    chk("slave clock", 32'h0000_0001, {31'h0000_0000, sslave});
    chk("slave clock in", 32'h0000_0001, {31'h0000_0000, scli});
    chk("slave select", 32'h0000_0001, {31'h0000_0000, ssel});
    // Any other function code leaves pin 6 to port data
    wr(pss_pkg::IDX_FUNC_LOW, 8'h40);
    settle();
    chk("fallback pin6", 32'h0000_0001, {31'h0000_0000, pad_drive.level[6]});
    chk("fallback select", 32'h0000_0000, {31'h0000_0000, ssel});
    // Serial pin 4 set as output still ignores its port data bit
    wr(pss_pkg::IDX_PAD_HIGH, 8'hff);
    wr(pss_pkg::IDX_PAD_LOW, 8'hff);
    wr(pss_pkg::IDX_DIRECTION, 8'h00);
    settle();
    chk("pin4 out", 32'h0000_0000, {31'h0000_0000, pad_drive.level[4]});
    test_done();
  end
endmodule : testbench
